// File: bench/ext_irq_checker.sv
// Port-level checks for the pin interrupt unit
`timescale 1ns/10ps
`default_nettype none
module ext_irq_checker (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic [31:0] hrdata, // read data
  input wire logic hresp, // response
  input wire ext_irq_pkg::pin_bus_t pin_in, // pins
  input wire logic global_irq_en, // global enable
  input wire ext_irq_pkg::irq_vec_t irq_ack, // acks
  input wire ext_irq_pkg::irq_vec_t irq_req // requests
);
  import ext_irq_pkg::*;
  logic [2:0] quiet_r;
  pin_bus_t last_pin_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles since any pin moved; saturates so settled events are told apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_r <= 3'h0;
      last_pin_r <= '0;
    end else begin
      last_pin_r <= pin_in;
      if (pin_in != last_pin_r) begin
        quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
        quiet_r <= quiet_r + 3'h1;
      end
    end
  end
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite
    |=> hreadyout) else $error("write data phase stalled");
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not OKAY");
  rdata_pad_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  gie_gate_a: assert property (!global_irq_en |-> irq_req == '0)
    else $error("request without global enable");
  ack_clear_a: assert property ((irq_ack.group & irq_req.group) != 3'h0
    && quiet_r >= 3'h5 |=> (irq_req.group & $past(irq_ack.group)) == 3'h0)
    else $error("ack left group request up");
  grp_cause_a: assert property ((irq_req.group & ~$past(irq_req.group)) != 3'h0
    && $stable(global_irq_en) |-> quiet_r < 3'h7) else $error("group request without change");
endmodule
bind ext_pin_change_irq ext_irq_checker chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .pin_in, .global_irq_en, .irq_ack, .irq_req);
`default_nettype wire

// File: bench/ext_pin_change_irq_tb.sv
// Self-checking bench for the pin interrupt unit
`timescale 1ns/10ps
`default_nettype none
`include "ext_irq_params.svh"
module ext_pin_change_irq_tb;
  import ext_irq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, global_irq_en, auto_ack, wake_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  pin_bus_t pins, pin_in;
  irq_vec_t irq_ack, irq_req;
  int bad_count, cmp_count, g;
  logic [7:0] regs [7] = '{`IDX_MASK_LOW, `IDX_MASK_MID, `IDX_MASK_HIGH, `IDX_SENSE,
    `IDX_FLAGS, `IDX_ENABLES, 8'h10};
  logic [7:0] wmask [7] = '{8'hFF, 8'h0F, 8'h3F, 8'h03, 8'h00, 8'h78, 8'h00};
  ext_pin_change_irq dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_in, .global_irq_en,
    .irq_ack, .irq_req, .wake_req);
  pin_core_model core_u (.hclk, .hresetn, .pins_cmd(pins), .auto_ack, .irq_req,
    .pin_in, .irq_ack);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single transfer; address held until ready is seen high
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk iff hreadyout === 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(nm, exp, rd);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    bad_count++;
    wrap_up();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    pins = '0;
    global_irq_en = 1'b0;
    auto_ack = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    tick(20);
    hresetn <= 1'b1;
    tick(1);
    foreach (regs[j]) rdc("reset value", regs[j], 32'h0);
    foreach (regs[j]) begin
      bus(1'b1, regs[j], 8'hFF);
      rdc("access bits", regs[j], {24'h0, wmask[j]});
    end
    $display("register test done");
    bus(1'b1, `IDX_ENABLES, 8'h38);
    global_irq_en <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      g = (i < 8) ? 0 : (i < 12) ? 1 : 2;
      pins.pin_change_input[i] <= ~pins.pin_change_input[i];
      tick(1);
      check("change wake", 32'h1, {31'h0, wake_req});
      tick(7);
      check("wake settled", 32'h0, {31'h0, wake_req});
      check("group req", 32'h1 << g, {29'h0, irq_req.group});
      rdc("group flag", `IDX_FLAGS, 32'h8 << g);
      bus(1'b1, `IDX_FLAGS, 8'h00);
      rdc("flag kept", `IDX_FLAGS, 32'h8 << g);
      bus(1'b1, `IDX_FLAGS, 8'h08 << g);
      rdc("flag cleared", `IDX_FLAGS, 32'h0);
    end
    $display("pin change test done");
    bus(1'b1, `IDX_MASK_LOW, 8'hFE);
    pins.pin_change_input[0] <= 1'b0;
    tick(8);
    rdc("masked pin", `IDX_FLAGS, 32'h0);
    bus(1'b1, `IDX_ENABLES, 8'h00);
    pins.pin_change_input[8] <= 1'b0;
    tick(8);
    rdc("group off", `IDX_FLAGS, 32'h0);
    bus(1'b1, `IDX_ENABLES, 8'h38);
    global_irq_en <= 1'b0;
    pins.pin_change_input[12] <= 1'b0;
    tick(8);
    check("gated req", 32'h0, {29'h0, irq_req.group});
    rdc("flag ungated", `IDX_FLAGS, 32'h20);
    global_irq_en <= 1'b1;
    tick(3);
    check("global on", 32'h4, {29'h0, irq_req.group});
    auto_ack <= 1'b1;
    tick(4);
    auto_ack <= 1'b0;
    rdc("acked flag", `IDX_FLAGS, 32'h0);
    $display("mask and ack test done");
    bus(1'b1, `IDX_ENABLES, 8'h40);
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, `IDX_SENSE, 8'(m));
      pins.dedicated <= 1'b1;
      tick(8);
      rdc("rise flag", `IDX_FLAGS, (m != 2) ? 32'h40 : 32'h0);
      check("rise req", {31'h0, m != 2}, {31'h0, irq_req.dedicated});
      bus(1'b1, `IDX_FLAGS, 8'h40);
      pins.dedicated <= 1'b0;
      tick(8);
      rdc("fall flag", `IDX_FLAGS, (m != 3) ? 32'h40 : 32'h0);
      bus(1'b1, `IDX_FLAGS, 8'h40);
    end
    bus(1'b1, `IDX_SENSE, 8'h01);
    pins.dedicated <= 1'b1;
    tick(2);
    pins.dedicated <= 1'b0;
    tick(8);
    rdc("short pulse", `IDX_FLAGS, 32'h40);
    $display("edge test done");
    bus(1'b1, `IDX_SENSE, 8'h00);
    tick(6);
    check("low req", 32'h1, {31'h0, irq_req.dedicated});
    check("low wake", 32'h1, {31'h0, wake_req});
    rdc("low flag", `IDX_FLAGS, 32'h0);
    global_irq_en <= 1'b0;
    tick(1);
    check("low gated", 32'h0, {31'h0, irq_req.dedicated});
    global_irq_en <= 1'b1;
    pins.dedicated <= 1'b1;
    tick(6);
    check("high no req", 32'h0, {31'h0, irq_req.dedicated});
    check("high no wake", 32'h0, {31'h0, wake_req});
    bus(1'b1, `IDX_ENABLES, 8'h00);
    pins.dedicated <= 1'b0;
    tick(6);
    check("enable off", 32'h0, {31'h0, irq_req.dedicated});
    $display("low level test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: bench/pin_core_model.sv
// Outside pins and the core's vector taking
`timescale 1ns/10ps
`default_nettype none
module pin_core_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire ext_irq_pkg::pin_bus_t pins_cmd, // wanted levels
  input wire logic auto_ack, // core takes vectors
  input wire ext_irq_pkg::irq_vec_t irq_req, // requests
  output wire ext_irq_pkg::pin_bus_t pin_in, // pins to unit
  output var ext_irq_pkg::irq_vec_t irq_ack // vector taken
);
  import ext_irq_pkg::*;
  // Levels held as long as the bench asks, also while driven as outputs
  assign pin_in = pins_cmd;
  // Gap cycle between pulses lets a cleared flag drop first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack <= '0;
    end else if (auto_ack && irq_ack == '0) begin
      irq_ack <= irq_req;
    end else begin
      irq_ack <= '0;
    end
  end
endmodule
`default_nettype wire

// File: logic/ext_irq_params.svh
// Offsets, field positions, reset values and codes of the pin interrupt unit
// Operation
// - Sense field picks low level, any change, falling or rising edge for dedicated pin
// - Dedicated pin is sampled before edge detection; long pulses always request
// - Dedicated pin request needs its enable bit 6 and global enable
// - Pin activity requests even when the pin is driven as output
// - Group 2 enable bit 5 plus global enable; pins 17 to 12
// - Group 1 enable bit 4 plus global enable; pins 11 to 8
// - Group 0 enable bit 3 plus global enable; pins 7 to 0
// - Dedicated flag bit 6 sets on pin activity; request when flag and enables set
// - Each flag clears when the core runs its handler
// - Writing one clears a flag; writing zero leaves it
// - In low-level mode dedicated flag reads zero; request follows pin level
// - Group flags at bits 5, 4, 3 set on change in group 2, 1, 0
// - A pin counts only with its mask bit and its group enable set
// - Mask bits map one-to-one onto pins across three mask registers
// - Reserved bits read zero and ignore writes
// - Pin change detection also works without clock for wake-up
// - Edge modes need the clock; low level wakes without it
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

`define IDX_MASK_LOW 8'h27
`define IDX_MASK_MID 8'h28
`define IDX_MASK_HIGH 8'h29
`define IDX_SENSE 8'h36
`define IDX_FLAGS 8'h3B
`define IDX_ENABLES 8'h3C

`define BIT_DEDICATED 6
`define BIT_GROUP2 5
`define BIT_GROUP1 4
`define BIT_GROUP0 3
`define SENSE_MSB 1
`define SENSE_LSB 0

`define WIDTH_MASK_LOW 8
`define WIDTH_MASK_MID 4
`define WIDTH_MASK_HIGH 6
`define NUM_PC_PINS 18
`define NUM_GROUPS 3

`define RST_MASK_LOW 8'h00
`define RST_MASK_MID 4'h0
`define RST_MASK_HIGH 6'h00
`define RST_SENSE 2'h0

`define SENSE_CODE_LOW 2'h0
`define SENSE_CODE_ANY 2'h1
`define SENSE_CODE_FALL 2'h2
`define SENSE_CODE_RISE 2'h3

`define GROUP0_PINS 18'h0_00FF
`define GROUP1_PINS 18'h0_0F00
`define GROUP2_PINS 18'h3_F000

`endif

// File: logic/ext_irq_pkg.sv
// Types shared by the pin interrupt unit
package ext_irq_pkg;

  // One bit per interrupt source
  typedef struct packed {
    logic dedicated;
    logic [2:0] group;
  } irq_vec_t;

  // Raw external pins watched by the unit
  typedef struct packed {
    logic dedicated;
    logic [17:0] pin_change_input;
  } pin_bus_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RWAIT,
    BUS_RDONE
  } bus_state_t;

endpackage

// File: logic/ext_pin_change_irq.sv
// External pin and pin change interrupt unit with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "ext_irq_params.svh"
module ext_pin_change_irq (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire ext_irq_pkg::pin_bus_t pin_in, // Raw pins
  input wire logic global_irq_en, // Core status word I bit
  input wire ext_irq_pkg::irq_vec_t irq_ack, // Core vector taken
  output ext_irq_pkg::irq_vec_t irq_req, // Requests to core
  output logic wake_req // Clockless wake-up
);
  import ext_irq_pkg::*;

  // Bus slave state
  bus_state_t state_r;
  logic [7:0] idx_r;
  logic mapped_r;
  logic accept;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [31:0] hrdata_r;
  logic wr_mask_low;
  logic wr_mask_mid;
  logic wr_mask_high;
  logic wr_sense;
  logic wr_flags;
  logic wr_enables;
  logic [7:0] flags_byte;
  logic [7:0] enables_byte;

  // Register contents
  logic [`WIDTH_MASK_LOW-1:0] mask_low_r;
  logic [`WIDTH_MASK_MID-1:0] mask_mid_r;
  logic [`WIDTH_MASK_HIGH-1:0] mask_high_r;
  logic [1:0] sense_r;
  irq_vec_t enables_r;
  irq_vec_t flags_r;

  // Pin path
  logic [`NUM_PC_PINS:0] stable;
  logic [`NUM_PC_PINS:0] prev_r;
  logic [`NUM_PC_PINS-1:0] pc_mask;
  logic [`NUM_PC_PINS-1:0] pc_change;
  logic [`NUM_PC_PINS-1:0] grp_en_bits;
  logic ded_stable;
  logic ded_prev;
  logic ded_rise;
  logic ded_fall;
  logic ded_event;
  logic level_mode;
  logic [`NUM_GROUPS-1:0] grp_hit;
  irq_vec_t flag_clr;
  // Request and wake helpers
  irq_vec_t armed;
  logic ded_pending;
  logic [`NUM_PC_PINS-1:0] pc_live;
  logic wake_level;
  logic [`NUM_PC_PINS-1:0] raw_change;
  logic wake_change;

  // Address phase taken on hready with NONSEQ or SEQ
  assign accept = hsel & hready & htrans[1];

  // Phase tracker; a read stalls one cycle, a write none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= BUS_IDLE;
    end else begin
      case (state_r)
        BUS_RWAIT: begin
          state_r <= BUS_RDONE;
        end
        BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
          if (accept) begin
            state_r <= hwrite ? BUS_WRITE : BUS_RWAIT;
          end else begin
            state_r <= BUS_IDLE;
          end
        end
        default: begin
          state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= 8'h00;
      mapped_r <= 1'b0;
    end else if (accept) begin
      idx_r <= haddr[9:2];
      // Only aligned whole-word transfers with clear upper bits reach a register
      mapped_r <= (haddr[31:10] == 22'h00_0000) &
        (haddr[1:0] == 2'h0) &
        (hsize == 3'h2);
    end
  end

  // One wait state on reads so read data comes from a flop
  assign hreadyout = (state_r != BUS_RWAIT);
  assign hresp = 1'b0;
  assign wr_en = (state_r == BUS_WRITE) & mapped_r;
  assign wr_byte = hwdata[7:0];

  // Per-register write strobes, live in the write data phase only
  assign wr_mask_low = wr_en & (idx_r == `IDX_MASK_LOW);
  assign wr_mask_mid = wr_en & (idx_r == `IDX_MASK_MID);
  assign wr_mask_high = wr_en & (idx_r == `IDX_MASK_HIGH);
  assign wr_sense = wr_en & (idx_r == `IDX_SENSE);
  assign wr_flags = wr_en & (idx_r == `IDX_FLAGS);
  assign wr_enables = wr_en & (idx_r == `IDX_ENABLES);

  // Flag and enable bytes share one layout; all other bits stay zero
  always_comb begin
    flags_byte = 8'h00;
    flags_byte[`BIT_DEDICATED] = flags_r.dedicated;
    flags_byte[`BIT_GROUP2] = flags_r.group[2];
    flags_byte[`BIT_GROUP1] = flags_r.group[1];
    flags_byte[`BIT_GROUP0] = flags_r.group[0];
    enables_byte = 8'h00;
    enables_byte[`BIT_DEDICATED] = enables_r.dedicated;
    enables_byte[`BIT_GROUP2] = enables_r.group[2];
    enables_byte[`BIT_GROUP1] = enables_r.group[1];
    enables_byte[`BIT_GROUP0] = enables_r.group[0];
  end

  // Read mux; reserved and unmapped bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (mapped_r) begin
      case (idx_r)
        `IDX_MASK_LOW: begin
          rd_byte = mask_low_r;
        end
        `IDX_MASK_MID: begin
          rd_byte = {4'h0, mask_mid_r};
        end
        `IDX_MASK_HIGH: begin
          rd_byte = {2'h0, mask_high_r};
        end
        `IDX_SENSE: begin
          rd_byte[`SENSE_MSB:`SENSE_LSB] = sense_r;
        end
        `IDX_FLAGS: begin
          rd_byte = flags_byte;
        end
        `IDX_ENABLES: begin
          rd_byte = enables_byte;
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (state_r == BUS_RWAIT) begin
      hrdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign hrdata = hrdata_r;

  // Mask registers, only defined bits stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_low_r <= `RST_MASK_LOW;
      mask_mid_r <= `RST_MASK_MID;
      mask_high_r <= `RST_MASK_HIGH;
    end else begin
      if (wr_mask_low) begin
        mask_low_r <= wr_byte;
      end
      if (wr_mask_mid) begin
        mask_mid_r <= wr_byte[`WIDTH_MASK_MID-1:0];
      end
      if (wr_mask_high) begin
        mask_high_r <= wr_byte[`WIDTH_MASK_HIGH-1:0];
      end
    end
  end

  // Sense field; sleep bits sharing this register are not kept here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_r <= `RST_SENSE;
    end else if (wr_sense) begin
      sense_r <= wr_byte[`SENSE_MSB:`SENSE_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enables_r <= '0;
    end else if (wr_enables) begin
      enables_r.dedicated <= wr_byte[`BIT_DEDICATED];
      enables_r.group[2] <= wr_byte[`BIT_GROUP2];
      enables_r.group[1] <= wr_byte[`BIT_GROUP1];
      enables_r.group[0] <= wr_byte[`BIT_GROUP0];
    end
  end

  // Pins are sampled whatever their port direction
  pin_filter_sync #(
    .WIDTH(`NUM_PC_PINS + 1)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in({pin_in.dedicated, pin_in.pin_change_input}),
    .stable_out(stable)
  );

  // History resets low like the filter output, so reset brings no false edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= stable;
    end
  end

  // Dedicated pin edge detect on sampled level
  assign ded_stable = stable[`NUM_PC_PINS];
  assign ded_prev = prev_r[`NUM_PC_PINS];
  assign ded_rise = ded_stable & ~ded_prev;
  assign ded_fall = ~ded_stable & ded_prev;
  assign level_mode = (sense_r == `SENSE_CODE_LOW);

  always_comb begin
    ded_event = 1'b0;
    case (sense_r)
      `SENSE_CODE_ANY: begin
        ded_event = ded_rise | ded_fall;
      end
      `SENSE_CODE_FALL: begin
        ded_event = ded_fall;
      end
      `SENSE_CODE_RISE: begin
        ded_event = ded_rise;
      end
      default: begin
        ded_event = 1'b0;
      end
    endcase
  end

  // Per-pin gating by mask and group enable
  assign pc_mask = {mask_high_r, mask_mid_r, mask_low_r};
  assign pc_change = stable[`NUM_PC_PINS-1:0] ^ prev_r[`NUM_PC_PINS-1:0];
  // A pin counts only with its own mask bit set
  assign pc_live = pc_change & pc_mask;
  assign grp_en_bits = ({`NUM_PC_PINS{enables_r.group[0]}} & `GROUP0_PINS)
    | ({`NUM_PC_PINS{enables_r.group[1]}} & `GROUP1_PINS)
    | ({`NUM_PC_PINS{enables_r.group[2]}} & `GROUP2_PINS);

  // Write-one-to-clear or core acknowledge
  always_comb begin
    flag_clr = irq_ack;
    if (wr_flags) begin
      flag_clr.dedicated = irq_ack.dedicated | wr_byte[`BIT_DEDICATED];
      flag_clr.group[2] = irq_ack.group[2] | wr_byte[`BIT_GROUP2];
      flag_clr.group[1] = irq_ack.group[1] | wr_byte[`BIT_GROUP1];
      flag_clr.group[0] = irq_ack.group[0] | wr_byte[`BIT_GROUP0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_GROUPS; g++) begin : g_group
      localparam logic [`NUM_PC_PINS-1:0] SEL = (g == 0) ? `GROUP0_PINS :
        (g == 1) ? `GROUP1_PINS : `GROUP2_PINS;
      assign grp_hit[g] = |(pc_live & SEL) & enables_r.group[g];

      // New event wins over a clear in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flags_r.group[g] <= 1'b0;
        end else if (grp_hit[g]) begin
          flags_r.group[g] <= 1'b1;
        end else if (flag_clr.group[g]) begin
          flags_r.group[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Dedicated flag held clear in level mode
  // An edge wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r.dedicated <= 1'b0;
    end else if (level_mode) begin
      flags_r.dedicated <= 1'b0;
    end else if (ded_event) begin
      flags_r.dedicated <= 1'b1;
    end else if (flag_clr.dedicated) begin
      flags_r.dedicated <= 1'b0;
    end
  end

  // A source is armed only with its own enable and the core's global enable
  always_comb begin
    armed.dedicated = global_irq_en & enables_r.dedicated;
    armed.group[2] = global_irq_en & enables_r.group[2];
    armed.group[1] = global_irq_en & enables_r.group[1];
    armed.group[0] = global_irq_en & enables_r.group[0];
  end

  // Level mode presents the filtered pin, so the request drops once the pin rises
  assign ded_pending = level_mode ? ~ded_stable : flags_r.dedicated;

  // Requests to the core
  always_comb begin
    irq_req.dedicated = armed.dedicated & ded_pending;
    irq_req.group = armed.group & flags_r.group;
  end

  // Clockless wake path; edge modes cannot wake, they need the clock
  assign wake_level = enables_r.dedicated & level_mode & ~pin_in.dedicated;
  // Raw pins against the filtered copy, so a change shows before the flops see it
  assign raw_change = pin_in.pin_change_input ^ stable[`NUM_PC_PINS-1:0];
  assign wake_change = |(raw_change & pc_mask & grp_en_bits);
  assign wake_req = global_irq_en & (wake_level | wake_change);

endmodule
`default_nettype wire

// File: logic/pin_filter_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_filter_sync #(
  parameter int WIDTH = 19
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels
  output logic [WIDTH-1:0] stable_out // Filtered levels
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] check_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
          check_r[i] <= 1'b0;
          stable_out[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
          check_r[i] <= sync_r[i];
          // Change accepted only when stages two and three agree
          if (sync_r[i] == check_r[i]) begin
            stable_out[i] <= check_r[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire
